// ==== common/pmcd_pkg.sv ====
`default_nettype none
package pmcd_pkg;
    // ----------------------------------------------------------------
    // card geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int PAGE_W     = 2;
    localparam int SEG_W      = 3;
    localparam int NBANKS     = 4;
    localparam int BANK_AW    = 10;
    localparam int PAGE_LSB   = 13;
    localparam int SEG_LSB    = 10;

    // ----------------------------------------------------------------
    // apb register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] CFG_OFF    = 12'h000;
    localparam logic [11:0] MAP_OFF    = 12'h004;
    localparam logic [11:0] STATUS_OFF = 12'h008;
    localparam logic [11:0] COUNT_OFF  = 12'h00C;

    // cfg fields
    localparam int CFG_PAGE_LSB = 0;
    localparam int CFG_EN_BIT   = 8;
    // map fields: bank i segment at bits 4*i+2 .. 4*i
    localparam int MAP_FIELD_W  = 4;
    // status fields
    localparam int ST_BANK_LSB  = 0;
    localparam int ST_BUSY_BIT  = 4;
    localparam int ST_WR_BIT    = 5;

    // reset values: page 0, banks on segments 2,3,4,5, card enabled
    localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
    localparam logic              EN_RST   = 1'b1;
    localparam logic [15:0]       MAP_RST  = 16'h5432;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              write;
        logic              wpulse;
        logic              req;
        logic              dma_req_n;
        logic              mem_sel;
    } pmcd_bus_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_ACK   = 4'h8
    } pmcd_state_e;
endpackage
`default_nettype wire

// ==== hw/pmcd_bank_array.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmcd_bank_array (
    input  wire logic                               pclk,       // system clock
    input  wire logic [1:0]                         bank_idx,   // selected bank
    input  wire logic                               we,         // write strobe
    input  wire logic [pmcd_pkg::BANK_AW-1:0]       addr,       // offset in bank
    input  wire logic [pmcd_pkg::DATA_W-1:0]        wdata,      // write byte
    output logic      [pmcd_pkg::DATA_W-1:0]        rdata_q     // registered read
);
    // ----------------------------------------------------------------
    // four byte-wide 1 KB banks
    // ----------------------------------------------------------------
    logic [pmcd_pkg::DATA_W-1:0] mem [0:pmcd_pkg::NBANKS*(2**pmcd_pkg::BANK_AW)-1];
    wire  [11:0]                 index = {bank_idx, addr};

    // write on strobe, read every cycle
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[index] <= wdata;
        end
        rdata_q <= mem[index];
    end
endmodule // pmcd_bank_array
`default_nettype wire

// ==== hw/pmcd_card.sv ====
// How it works
// - decode only on memory request, either master
// - page field must match configured page
// - each bank enabled by its configured segment
// - four 1 KB banks, one per access
// - distinct configuration gives each card its range
// - selected bank passes direction and write pulse
// - acknowledge asserted when access completes
// - reset maps page 0, segments 2..5
`timescale 1ns/1ps
`default_nettype none
module pmcd_card (
    input  wire logic                          pclk,                      // clock
    input  wire logic                          presetn,                   // async reset
    input  wire logic                          psel,                      // apb select
    input  wire logic                          penable,                   // apb enable
    input  wire logic                          pwrite,                    // apb write
    input  wire logic [11:0]                   paddr,                     // apb address
    input  wire logic [31:0]                   pwdata,                    // apb write data
    output logic      [31:0]                   prdata,                    // apb read data
    output logic                               pready,                    // apb ready
    output logic                               pslverr,                   // apb error
    input  wire logic [pmcd_pkg::ADDR_W-1:0]   address_bus,               // card address
    input  wire logic [pmcd_pkg::DATA_W-1:0]   data_bus_in,               // data from bus
    output logic      [pmcd_pkg::DATA_W-1:0]   data_bus_out,              // data to bus
    output logic                               data_bus_oe,               // data drive enable
    input  wire logic                          read_write,                // high = write
    input  wire logic                          write_pulse,               // write strobe
    input  wire logic                          operation_request,         // cpu request
    input  wire logic                          dma_operation_request_n,   // dma request
    input  wire logic                          mem_io_select,             // high = memory
    output logic                               operation_acknowledge_n    // acknowledge
);
    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [pmcd_pkg::PAGE_W-1:0] page_q;
    logic                        card_en_q;
    logic [15:0]                 map_q;
    logic [15:0]                 count_q;
    logic                        last_wr_q;

    // ----------------------------------------------------------------
    // input synchroniser
    // ----------------------------------------------------------------
    pmcd_pkg::pmcd_bus_s pin_w;
    pmcd_pkg::pmcd_bus_s sync1_q;
    pmcd_pkg::pmcd_bus_s sync2_q;

    // gather the pins into one carrier
    assign pin_w.addr      = address_bus;
    assign pin_w.wdata     = data_bus_in;
    assign pin_w.write     = read_write;
    assign pin_w.wpulse    = write_pulse;
    assign pin_w.req       = operation_request;
    assign pin_w.dma_req_n = dma_operation_request_n;
    assign pin_w.mem_sel   = mem_io_select;

    // two stages; pins held stable by the master while requesting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_w;
            sync2_q <= sync1_q;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // one bit per bank whose configured segment matches; several can be set
    function automatic logic [pmcd_pkg::NBANKS-1:0] bank_match(
        input logic [15:0]                map,
        input logic [pmcd_pkg::SEG_W-1:0] seg
    );
        logic [pmcd_pkg::NBANKS-1:0] hit;
        hit = '0;
        for (int i = 0; i < pmcd_pkg::NBANKS; i++) begin
            hit[i] = (map[i*pmcd_pkg::MAP_FIELD_W +: pmcd_pkg::SEG_W] == seg);
        end
        return hit;
    endfunction

    // priority pick keeps at most one bank live
    function automatic logic [1:0] first_bank(input logic [pmcd_pkg::NBANKS-1:0] hit);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = pmcd_pkg::NBANKS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    wire                               any_req_w;
    wire                               mem_req_w;
    wire [pmcd_pkg::PAGE_W-1:0]        page_fld_w;
    wire [pmcd_pkg::SEG_W-1:0]         seg_fld_w;
    wire                               page_hit_w;
    wire [pmcd_pkg::NBANKS-1:0]        bank_hit_w;
    wire                               card_sel_w;
    wire [1:0]                         bank_idx_w;

    // request qualification and two-stage decode
    assign any_req_w  = sync2_q.req | ~sync2_q.dma_req_n;
    assign mem_req_w  = any_req_w & sync2_q.mem_sel & card_en_q;
    assign page_fld_w = sync2_q.addr[pmcd_pkg::PAGE_LSB +: pmcd_pkg::PAGE_W];
    assign seg_fld_w  = sync2_q.addr[pmcd_pkg::SEG_LSB +: pmcd_pkg::SEG_W];
    assign page_hit_w = (page_fld_w == page_q);
    assign bank_hit_w = bank_match(map_q, seg_fld_w);
    assign card_sel_w = mem_req_w & page_hit_w & (|bank_hit_w);
    assign bank_idx_w = first_bank(bank_hit_w);

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    pmcd_pkg::pmcd_state_e state_q;
    pmcd_pkg::pmcd_state_e state_d;
    logic [pmcd_pkg::DATA_W-1:0] rdata_w;
    wire                         ram_we_w;
    wire                         start_w;

    // write pulse passes to the array only for the selected bank
    assign ram_we_w = (state_q == pmcd_pkg::ST_WRITE) & card_sel_w
                    & sync2_q.write & sync2_q.wpulse;
    assign start_w  = (state_q == pmcd_pkg::ST_IDLE) & card_sel_w;

    // next-state logic
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pmcd_pkg::ST_IDLE: begin
                if (card_sel_w) begin
                    state_d = sync2_q.write ? pmcd_pkg::ST_WRITE : pmcd_pkg::ST_READ;
                end
            end
            pmcd_pkg::ST_READ: begin
                state_d = card_sel_w ? pmcd_pkg::ST_ACK : pmcd_pkg::ST_IDLE;
            end
            pmcd_pkg::ST_WRITE: begin
                if (!card_sel_w) begin
                    state_d = pmcd_pkg::ST_IDLE;
                end else if (ram_we_w) begin
                    state_d = pmcd_pkg::ST_ACK;
                end
            end
            pmcd_pkg::ST_ACK: begin
                if (!any_req_w) begin
                    state_d = pmcd_pkg::ST_IDLE;
                end
            end
            default: state_d = pmcd_pkg::ST_IDLE;
        endcase
    end

    // bank storage
    pmcd_bank_array u_array (
        .pclk     (pclk),
        .bank_idx (bank_idx_w),
        .we       (ram_we_w),
        .addr     (sync2_q.addr[pmcd_pkg::BANK_AW-1:0]),
        .wdata    (sync2_q.wdata),
        .rdata_q  (rdata_w)
    );

    // state, acknowledge and data drivers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q                 <= pmcd_pkg::ST_IDLE;
            operation_acknowledge_n <= 1'b1;
            data_bus_oe             <= 1'b0;
            data_bus_out            <= '0;
        end else begin
            state_q <= state_d;
            operation_acknowledge_n <= (state_d != pmcd_pkg::ST_ACK);
            data_bus_oe <= (state_d == pmcd_pkg::ST_ACK) & ~sync2_q.write;
            if (state_q == pmcd_pkg::ST_READ) begin
                data_bus_out <= rdata_w;
            end
        end
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    wire        setup_w  = psel & ~penable;
    wire        wr_en_w  = psel & penable & pready & pwrite;
    wire        map_ok_w = (paddr == pmcd_pkg::CFG_OFF) | (paddr == pmcd_pkg::MAP_OFF)
                         | (paddr == pmcd_pkg::STATUS_OFF) | (paddr == pmcd_pkg::COUNT_OFF);
    logic [31:0] rd_mux_w;

    // read data selection
    always_comb begin
        rd_mux_w = '0;
        if (paddr == pmcd_pkg::CFG_OFF) begin
            rd_mux_w[pmcd_pkg::CFG_PAGE_LSB +: pmcd_pkg::PAGE_W] = page_q;
            rd_mux_w[pmcd_pkg::CFG_EN_BIT]                       = card_en_q;
        end else if (paddr == pmcd_pkg::MAP_OFF) begin
            rd_mux_w[15:0] = map_q;
        end else if (paddr == pmcd_pkg::STATUS_OFF) begin
            rd_mux_w[pmcd_pkg::ST_BANK_LSB +: pmcd_pkg::NBANKS] =
                (state_q == pmcd_pkg::ST_IDLE) ? 4'h0 : (4'h1 << bank_idx_w);
            rd_mux_w[pmcd_pkg::ST_BUSY_BIT] = (state_q != pmcd_pkg::ST_IDLE);
            rd_mux_w[pmcd_pkg::ST_WR_BIT]   = last_wr_q;
        end else if (paddr == pmcd_pkg::COUNT_OFF) begin
            rd_mux_w[15:0] = count_q;
        end
    end

    // answer registered in setup, ready in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup_w;
            pslverr <= setup_w & ~map_ok_w;
            if (setup_w) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux_w;
            end
        end
    end

    // configuration writes and access bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q    <= pmcd_pkg::PAGE_RST;
            card_en_q <= pmcd_pkg::EN_RST;
            map_q     <= pmcd_pkg::MAP_RST;
            count_q   <= '0;
            last_wr_q <= 1'b0;
        end else begin
            if (wr_en_w && paddr == pmcd_pkg::CFG_OFF) begin
                page_q    <= pwdata[pmcd_pkg::CFG_PAGE_LSB +: pmcd_pkg::PAGE_W];
                card_en_q <= pwdata[pmcd_pkg::CFG_EN_BIT];
            end
            if (wr_en_w && paddr == pmcd_pkg::MAP_OFF) begin
                map_q <= pwdata[15:0] & 16'h7777;
            end
            if (wr_en_w && paddr == pmcd_pkg::COUNT_OFF) begin
                count_q <= '0;
            end else if (start_w) begin
                count_q <= count_q + 16'h0001;
            end
            if (start_w) begin
                last_wr_q <= sync2_q.write;
            end
        end
    end
endmodule // pmcd_card
`default_nettype wire

// ==== testbench/paged_memory_card_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module paged_memory_card_decoder_test;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    wire  [31:0] prdata;
    wire         pready, pslverr, oe, rw, wp, rq, dq_n, mio, ack_n;
    wire  [14:0] abus;
    wire  [7:0]  din, dout;
    int          err_count = 0, n_compared = 0;
    logic [1:0]  page = 2'h0;
    logic        en = 1'b1;
    logic [15:0] map = 16'h5432;
    logic [7:0]  ref_mem [int];
    logic [15:0] hc [7] = '{16'h0800, 16'h17FF, 16'h07FF, 16'h1800, 16'h2800, 16'h8C00, 16'h4C00};
    always #5 pclk = ~pclk;
    pmcd_card uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .address_bus(abus), .data_bus_in(din), .data_bus_out(dout),
        .data_bus_oe(oe), .read_write(rw), .write_pulse(wp), .operation_request(rq),
        .dma_operation_request_n(dq_n), .mem_io_select(mio), .operation_acknowledge_n(ack_n));
    pmcd_bus_master m (.pclk, .address_bus(abus), .data_bus_in(din), .data_bus_out(dout),
        .data_bus_oe(oe), .read_write(rw), .write_pulse(wp), .operation_request(rq),
        .dma_operation_request_n(dq_n), .mem_io_select(mio), .operation_acknowledge_n(ack_n));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; pready ends this wait, the hang guard only if it never comes
        do begin @(posedge pclk); end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic int bank_of(input logic [14:0] a);
        for (int i = 0; i < 4; i++)
            if (en && a[14:13] == page && map[4*i +: 3] == a[12:10]) return i;
        return -1;
    endfunction
    // write a byte then read it back, checking selection and data
    task automatic run(input logic dma, input logic mem, input logic [14:0] a);
        logic ack;
        logic [7:0] rd, d;
        int b;
        b = mem ? bank_of(a) : -1;
        d = 8'($urandom);
        m.access(dma, 1'b1, mem, a, d, $urandom_range(3), ack, rd);
        chk("write ack", b >= 0, ack);
        if (b >= 0) ref_mem[b*1024 + a[9:0]] = d;
        m.access(dma, 1'b0, mem, a, 8'h00, $urandom_range(3), ack, rd);
        chk("read ack", b >= 0, ack);
        if (b >= 0) chk("read data", ref_mem[b*1024 + a[9:0]], rd);
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        r = $urandom(32);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pmcd_pkg::CFG_OFF, '0, r, e);
        chk("cfg reset", 32'h0000_0100, r);
        chk("cfg error", 32'h0, e);
        apb(1'b0, pmcd_pkg::MAP_OFF, '0, r, e);
        chk("map reset", 32'h0000_5432, r);
        apb(1'b0, 12'h010, '0, r, e);
        chk("unmapped error", 32'h1, e);
        foreach (hc[i]) run(hc[i][15], 1'b1, hc[i][14:0]);
        run(1'b0, 1'b0, 15'h0800);
        apb(1'b0, pmcd_pkg::STATUS_OFF, '0, r, e);
        chk("status idle", 32'h0, r);
        apb(1'b0, pmcd_pkg::COUNT_OFF, '0, r, e);
        chk("access count", 32'h6, r);
        for (int k = 0; k < 12; k++) begin
            page = 2'($urandom);
            en   = ($urandom_range(3) != 0);
            map  = 16'($urandom) & 16'h7777;
            apb(1'b1, pmcd_pkg::CFG_OFF, {23'h0, en, 6'h0, page}, r, e);
            apb(1'b1, pmcd_pkg::MAP_OFF, {16'h0, map}, r, e);
            apb(1'b0, pmcd_pkg::MAP_OFF, '0, r, e);
            chk("map", {16'h0, map}, r);
            repeat (4) run(1'($urandom), 1'b1, {page, 13'($urandom)});
            run(1'b0, 1'b1, 15'($urandom));
        end
        give_verdict();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        give_verdict();
    end
endmodule // paged_memory_card_decoder_test
`default_nettype wire

// ==== testbench/pmcd_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmcd_bus_master (
    input  wire logic        pclk,                    // clock
    output logic      [14:0] address_bus,             // address
    output logic      [7:0]  data_bus_in,             // resolved data wire
    input  wire logic [7:0]  data_bus_out,            // card data
    input  wire logic        data_bus_oe,             // card drives
    output logic             read_write,              // high = write
    output logic             write_pulse,             // write strobe
    output logic             operation_request,       // cpu request
    output logic             dma_operation_request_n, // dma request
    output logic             mem_io_select,           // high = memory
    input  wire logic        operation_acknowledge_n  // acknowledge
);
    logic [7:0] drv_q = 8'h00;
    // wire level: card wins while it drives, else the master's byte
    assign data_bus_in = data_bus_oe ? data_bus_out : drv_q;
    initial begin
        {address_bus, read_write, write_pulse, operation_request, mem_io_select} = '0;
        dma_operation_request_n = 1'b1;
    end
    // one byte access, held until acknowledge or give-up
    task automatic access(input logic dma, input logic wr, input logic mem,
                          input logic [14:0] a, input logic [7:0] d, input int slow,
                          output logic ack, output logic [7:0] rd);
        int n;
        ack = 1'b0;
        rd  = 8'hXX;
        @(posedge pclk);
        address_bus   <= a;
        read_write    <= wr;
        mem_io_select <= mem;
        drv_q         <= wr ? d : ~drv_q;
        if (dma) dma_operation_request_n <= 1'b0;
        else operation_request <= 1'b1;
        for (n = 0; n < 20 && !ack; n++) begin
            @(posedge pclk);
            if (wr && n == 2 + slow) write_pulse <= 1'b1;
            ack = (operation_acknowledge_n === 1'b0);
            if (ack && data_bus_oe === 1'b1) rd = data_bus_out;
        end
        operation_request       <= 1'b0;
        dma_operation_request_n <= 1'b1;
        write_pulse             <= 1'b0;
        address_bus             <= ~a;
        drv_q                   <= ~drv_q;
        for (n = 0; n < 10 && operation_acknowledge_n !== 1'b1; n++) @(posedge pclk);
    endtask
endmodule // pmcd_bus_master
`default_nettype wire

// ==== testbench/pmcd_card_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmcd_card_asserts (
    input wire logic        pclk,                    // clock
    input wire logic        presetn,                 // reset
    input wire logic        psel,                    // apb select
    input wire logic        penable,                 // apb enable
    input wire logic        pwrite,                  // apb write
    input wire logic [11:0] paddr,                   // apb address
    input wire logic [31:0] pwdata,                  // apb wdata
    input wire logic [31:0] prdata,                  // apb rdata
    input wire logic        pready,                  // apb ready
    input wire logic [14:0] address_bus,             // card address
    input wire logic        read_write,              // high = write
    input wire logic        operation_request,       // cpu request
    input wire logic        dma_operation_request_n, // dma request
    input wire logic        mem_io_select,           // high = memory
    input wire logic        data_bus_oe,             // card drives bus
    input wire logic        operation_acknowledge_n  // acknowledge
);
    logic [1:0]  page_q;
    logic        en_q;
    logic [15:0] map_q;
    // --------------------------------------------------------------
    // shadow of the card configuration
    // --------------------------------------------------------------
    wire       wr_en = psel & penable & pready & pwrite;
    wire [2:0] seg   = address_bus[12:10];
    wire       req   = operation_request | ~dma_operation_request_n;
    wire       hit   = en_q & (address_bus[14:13] == page_q) & ((map_q[2:0] == seg)
                       | (map_q[6:4] == seg) | (map_q[10:8] == seg) | (map_q[14:12] == seg));
    // config updates on completed apb writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= pmcd_pkg::PAGE_RST;
            en_q   <= pmcd_pkg::EN_RST;
            map_q  <= pmcd_pkg::MAP_RST;
        end else if (wr_en && paddr == pmcd_pkg::CFG_OFF) begin
            page_q <= pwdata[1:0];
            en_q   <= pwdata[8];
        end else if (wr_en && paddr == pmcd_pkg::MAP_OFF) begin
            map_q  <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oe_with_ack: assert property (data_bus_oe |-> !operation_acknowledge_n)
        else $error("data bus driven without acknowledge");
    a_ack_needs_req: assert property ($fell(operation_acknowledge_n) |-> $past(req, 3))
        else $error("acknowledge without request");
    a_ack_mem_only: assert property ($fell(operation_acknowledge_n) |-> $past(mem_io_select, 3))
        else $error("acknowledge on io operation");
    a_ack_in_range: assert property ($fell(operation_acknowledge_n) |-> $past(hit, 3))
        else $error("acknowledge outside configured range");
    a_read_ack_time: assert property ($rose(req & mem_io_select & hit & !read_write)
        |-> ##[3:6] !operation_acknowledge_n)
        else $error("selected read not acknowledged in time");
    a_ack_release: assert property ($fell(req) |-> ##[1:5] operation_acknowledge_n)
        else $error("acknowledge held after request release");
    a_oe_read_only: assert property ($rose(data_bus_oe)
        |-> $past(!read_write & mem_io_select & hit, 2))
        else $error("data driven outside selected read");
    a_one_bank: assert property (psel & penable & pready & !pwrite
        & paddr == pmcd_pkg::STATUS_OFF |-> $onehot0(prdata[3:0]))
        else $error("more than one bank active");
endmodule // pmcd_card_asserts
bind pmcd_card pmcd_card_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .address_bus, .read_write, .operation_request,
    .dma_operation_request_n, .mem_io_select, .data_bus_oe, .operation_acknowledge_n);
`default_nettype wire
